//--- bench/alu_checker.sv
`timescale 1ns/1ns
module alu_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i && !ack_o;
    wire cmd = req && we_i && adr_i == 4'h9 && !busy_o;
    wire rd = req && !we_i;
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_answer: assert property (req |=> ack_o) else $error("no ack");
    a_ack_cause: assert property (!req |=> !ack_o) else $error("stray ack");
    a_mul_length: assert property (cmd && dat_i[4:0] == 5'h02 |=>
        busy_o[*8] ##1 busy_o[*8] ##1 busy_o ##1 !busy_o) else $error("mul length");
    a_shift_length: assert property (cmd && dat_i[5:0] == 6'h29 && dat_i[13:10] == 4'h4
        |=> busy_o[*4] ##1 !busy_o) else $error("shift length");
    a_busy_cause: assert property ($rose(busy_o) |-> $past(cmd)) else $error("busy");
    a_done_read: assert property (rd && adr_i == 4'h7
        |=> dat_o[9] == !$past(busy_o)) else $error("done flag");
    a_busy_read: assert property (rd && adr_i == 4'h9
        |=> dat_o[0] == $past(busy_o)) else $error("busy read");
endmodule
bind microcore_alu alu_checker alu_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .busy_o(busy_o));

//--- bench/alu_sequencer_model.sv
`timescale 1ns/1ns
module alu_sequencer_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdata_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    int stuck = 0;
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // one classic cycle, held until ack is sampled or 64 clocks pass
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!ack_i && n < 64);
        q = rdata_i;
        if (!ack_i) stuck++;
        {cyc_o, stb_o} <= 2'b00;
        dat_o <= ~d;
    endtask
endmodule

//--- bench/microcore_alu_datapath_bench.sv
`timescale 1ns/1ns
module microcore_alu_datapath_bench import alu_pkg::*; ;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, busy;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, e, m;
    logic [31:0] exp_q[$], msk_q[$];
    int n_errors = 0;
    int checks_done = 0;
    always #5 clk_i = ~clk_i;
    alu_sequencer_model alu_sequencer_model_inst (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    microcore_alu microcore_alu_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .busy_o(busy));
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 0) checks_done++;
            if ((rdat & m) !== (e & m)) begin
                n_errors++;
                $display("ERROR %0t read %h expected %h", $time, rdat, e);
            end
        end
    end
    task automatic wr(logic [3:0] a, logic [31:0] d);
        logic [31:0] q;
        alu_sequencer_model_inst.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] x, logic [31:0] k = 32'hFFFFFFFF);
        logic [31:0] q;
        exp_q.push_back(x);
        msk_q.push_back(k);
        alu_sequencer_model_inst.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic op(opcode_t o, logic [1:0] d, logic [1:0] b, logic s, logic [3:0] i);
        command_t c;
        c = '{rst: 1'b0, imm: i, src_b: b, dst: d, imm_sel: s, op: o};
        wr(4'h9, {17'h0, c});
    endtask
    task automatic wait_idle;
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            exp_q.push_back(32'h0);
            msk_q.push_back(32'h0);
            alu_sequencer_model_inst.xfer(1'b0, 4'h9, 32'h0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 40);
        if (q[0] !== 1'b0) begin
            n_errors++;
            $display("ERROR %0t busy never cleared", $time);
        end
    endtask
    task automatic summarize;
        n_errors += alu_sequencer_model_inst.stuck;
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #500000;
        n_errors++;
        summarize;
    end
    initial begin
        logic [15:0] a, b, r, k;
        logic c;
        logic [31:0] p;
        void'($urandom(99788));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h7, 32'h200);
        rd(4'hF, 32'h0);
        a = 16'($urandom);
        b = 16'($urandom);
        wr(4'h0, {16'h0, a});
        wr(4'h1, {16'h0, b});
        op(OP_ADD, 2'd0, 2'd1, 1'b0, 4'h0);
        {c, r} = {1'b0, a} + b;
        rd(4'h0, {16'h0, r});
        rd(4'h7, {30'h0, r == 16'h0, c}, 32'h3);
        wr(4'h2, {16'h0, r});
        op(OP_SUB, 2'd2, 2'd0, 1'b0, 4'h0);
        rd(4'h2, 32'h0);
        rd(4'h7, 32'h2, 32'h2);
        op(OP_ADD, 2'd1, 2'd0, 1'b1, 4'h7);
        op(OP_SUB, 2'd1, 2'd0, 1'b1, 4'h3);
        r = b + 16'h4;
        rd(4'h1, {16'h0, r});
        wr(4'h8, 32'h1);
        wr(4'h0, 32'h7FFF);
        op(OP_ADD, 2'd0, 2'd0, 1'b1, 4'h1);
        rd(4'h7, 32'h40, 32'h40);
        wr(4'h8, 32'h0);
        k = 16'($urandom);
        wr(4'h4, {16'h0, k});
        for (int j = 0; j < 4; j++) begin
            a = 16'($urandom);
            wr(4'h3, {16'h0, a});
            op(opcode_t'(5'(j + 3)), 2'd3, 2'd0, 1'b0, 4'h0);
            r = j == 0 ? a & k : j == 1 ? a | k : j == 2 ? a ^ k : ~a;
            rd(4'h3, {16'h0, r});
        end
        op(OP_SWAP, 2'd3, 2'd0, 1'b0, 4'h0);
        rd(4'h3, {16'h0, r[7:0], r[15:8]});
        wr(4'h0, 32'h8005);
        wr(4'h9, 32'h400F);
        rd(4'h0, 32'h0005);
        op(OP_TO_TWOS_COMPLEMENT_OP, 2'd0, 2'd0, 1'b0, 4'h0);
        rd(4'h0, 32'h8005);
        rd(4'h7, 32'h400, 32'h400);
        a = 16'($urandom);
        b = 16'($urandom);
        wr(4'h0, {16'h0, a});
        wr(4'h1, {16'h0, b});
        wr(4'h2, 32'h1234);
        op(OP_MUL, 2'd0, 2'd1, 1'b0, 4'h0);
        wr(4'h2, 32'h5555);
        op(OP_STAL, 2'd0, 2'd2, 1'b0, 4'h0);
        rd(4'h7, 32'h0, 32'h200);
        wait_idle;
        rd(4'h2, 32'h1234);
        rd(4'h8, 32'h2, 32'h3);
        p = {16'h0, a} * {16'h0, b};
        rd(4'h5, {16'h0, p[15:0]});
        rd(4'h6, {16'h0, p[31:16]});
        op(OP_WSHL, 2'd0, 2'd0, 1'b1, 4'h4);
        wait_idle;
        rd(4'h7, {24'h0, |p[31:28], 7'h0}, 32'h80);
        wr(4'h1, 32'h3);
        op(OP_WSHR, 2'd0, 2'd1, 1'b0, 4'h0);
        wait_idle;
        p = (p << 4) >> 3;
        rd(4'h5, {16'h0, p[15:0]});
        rd(4'h6, {16'h0, p[31:16]});
        a = 16'($urandom) | 16'h8000;
        wr(4'h3, {16'h0, a});
        op(OP_SHL, 2'd3, 2'd0, 1'b1, 4'h4);
        rd(4'h7, 32'h0, 32'h200);
        wait_idle;
        rd(4'h7, {25'h0, a[12], 6'h0}, 32'h40);
        r = a << 4;
        rd(4'h3, {16'h0, r});
        wr(4'h3, {16'h0, a});
        op(OP_SHR, 2'd3, 2'd1, 1'b0, 4'h0);
        wait_idle;
        r = a >> 3;
        rd(4'h3, {16'h0, r});
        wr(4'h3, {16'h0, a});
        op(OP_SHRS, 2'd3, 2'd0, 1'b1, 4'h2);
        wait_idle;
        r = $signed(a) >>> 2;
        rd(4'h3, {16'h0, r});
        wr(4'h3, {16'h0, a});
        op(OP_BYTE_L, 2'd3, 2'd0, 1'b0, 4'h0);
        wait_idle;
        r = a << 8;
        rd(4'h3, {16'h0, r});
        op(OP_BYTE_R, 2'd3, 2'd0, 1'b0, 4'h0);
        wait_idle;
        rd(4'h3, {24'h0, a[7:0]});
        rd(4'h7, 32'h200, 32'h200);
        summarize;
    end
endmodule

//--- logic/alu_map.svh
// Functional notes
// - add or subtract two 16-bit ALU registers as 16-bit values
// - immediate add/sub use a 4-bit operand; results go to an ALU register
// - add/sub set carry, zero, negative and the four range flags
// - sign-mode bit 0 chooses unsigned or signed add/sub; mode bit 1 is stored but unused
// - add and subtract finish in one cycle
// - multiply register by register or 4-bit immediate into wide product
// - multiplication takes seventeen cycles
// - done low while multiplying; product-shift flags in condition register
// - while busy, ignore every instruction except set-mode
// - mask AND/OR/XOR with immediate mask register, or invert, in place
// - mask operations finish in one cycle
// - wide product shifts left/right by register or 4-bit immediate amount
// - ALU register shifts by register, 4-bit immediate, or eight
// - signed shifts keep two's-complement sign on register or immediate amount
// - shift result returns to the register that was shifted
// - shift lasts as many cycles as positions shifted
// - shift result unavailable and done low until finished
// - byte swap exchanges bytes in place in one cycle
// - conversion sets MSB from last sign by XOR or replace, one cycle
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH
`define DATA_W 16
`define WIDE_W 32
`define REG_CNT 4
`define MUL_CYCLES 17
`define WB_ADDR_W 4
`define A_REG0 4'h0
`define A_REG3 4'h3
`define A_MASK 4'h4
`define A_WLO 4'h5
`define A_WHI 4'h6
`define A_COND 4'h7
`define A_CFG 4'h8
`define A_CMD 4'h9
`define F_CARRY 0
`define F_ZERO 1
`define F_NEG 2
`define F_UU 3
`define F_UO 4
`define F_SU 5
`define F_SO 6
`define F_MO 7
`define F_ML 8
`define F_DONE 9
`define F_CS 10
`endif

//--- logic/alu_pkg.sv
`include "alu_map.svh"
package alu_pkg;
    typedef enum logic [4:0] {
        OP_ADD = 5'h00, OP_SUB = 5'h01, OP_MUL = 5'h02, OP_AND = 5'h03,
        OP_OR = 5'h04, OP_XOR = 5'h05, OP_NOT = 5'h06, OP_WSHL = 5'h07,
        OP_WSHR = 5'h08, OP_SHL = 5'h09, OP_SHR = 5'h0A, OP_SHLS = 5'h0B,
        OP_SHRS = 5'h0C, OP_SWAP = 5'h0D, OP_TO_TWOS_COMPLEMENT_OP = 5'h0E, OP_TOINT = 5'h0F,
        OP_STAL = 5'h10, OP_BYTE_L = 5'h11, OP_BYTE_R = 5'h12
    } opcode_t;
    // command word: op[4:0], imm_sel[5], dst[7:6], src_b[9:8], imm[13:10], rst[14]
    typedef struct packed {
        logic rst;
        logic [3:0] imm;
        logic [1:0] src_b;
        logic [1:0] dst;
        logic imm_sel;
        opcode_t op;
    } command_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, ST_MUL = 3'b010, ST_SHIFT = 3'b100
    } state_t;
endpackage

//--- logic/microcore_alu.sv
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "alu_map.svh"
module microcore_alu import alu_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`WB_ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic busy_o
);
    logic [15:0] regs_reg [`REG_CNT];
    logic [15:0] regs_next [`REG_CNT];
    logic [15:0] mask_reg, mask_next;
    logic [31:0] wide_reg, wide_next;
    logic [10:0] cond_reg, cond_next;
    logic [1:0] mode_reg, mode_next;
    state_t state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [31:0] mcand_reg, mcand_next;
    logic [15:0] mplier_reg, mplier_next;
    logic [3:0] kind_reg, kind_next;
    logic [1:0] tgt_reg, tgt_next;
    logic [31:0] dat_next;
    logic ack_next;

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic req;
    logic wr_cmd;
    command_t cmd;
    logic [15:0] a_val, b_val, amt;
    assign req = cyc_i && stb_i && !ack_o;
    assign cmd = command_t'(dat_i[14:0]);
    assign wr_cmd = req && we_i && adr_i == `A_CMD && sel_i[0];
    assign a_val = regs_reg[cmd.dst];
    assign b_val = cmd.imm_sel ? {12'h000, cmd.imm} : regs_reg[cmd.src_b];

    always_comb begin
        logic [16:0] sum;
        logic sgn_a, sgn_b, sgn_r;
        logic [31:0] merged;
        for (int i = 0; i < `REG_CNT; i++) begin
            regs_next[i] = regs_reg[i];
        end
        mask_next = mask_reg;
        wide_next = wide_reg;
        cond_next = cond_reg;
        mode_next = mode_reg;
        state_next = state_reg;
        cnt_next = cnt_reg;
        mcand_next = mcand_reg;
        mplier_next = mplier_reg;
        kind_next = kind_reg;
        tgt_next = tgt_reg;
        sum = 17'h00000;
        sgn_a = 1'b0;
        sgn_b = 1'b0;
        sgn_r = 1'b0;
        merged = 32'h00000000;
        amt = b_val;
        ack_next = req;
        dat_next = 32'h00000000;
        // bus reads and data writes
        if (req && !we_i) begin
            if (adr_i <= `A_REG3) begin
                dat_next = {16'h0000, regs_reg[adr_i[1:0]]};
            end else if (adr_i == `A_MASK) begin
                dat_next = {16'h0000, mask_reg};
            end else if (adr_i == `A_WLO) begin
                dat_next = {16'h0000, wide_reg[15:0]};
            end else if (adr_i == `A_WHI) begin
                dat_next = {16'h0000, wide_reg[31:16]};
            end else if (adr_i == `A_COND) begin
                dat_next = {21'h000000, cond_reg};
            end else if (adr_i == `A_CFG) begin
                dat_next = {30'h00000000, mode_reg};
            end else if (adr_i == `A_CMD) begin
                dat_next = {31'h00000000, state_reg != ST_IDLE};
            end
        end
        if (req && we_i && state_reg == ST_IDLE) begin
            if (adr_i <= `A_REG3) begin
                merged = lane_merge({16'h0000, regs_reg[adr_i[1:0]]}, dat_i, sel_i);
                regs_next[adr_i[1:0]] = merged[15:0];
            end else if (adr_i == `A_MASK) begin
                merged = lane_merge({16'h0000, mask_reg}, dat_i, sel_i);
                mask_next = merged[15:0];
            end
        end
        if (req && we_i && adr_i == `A_CFG && sel_i[0]) begin
            mode_next = dat_i[1:0];
        end
        // instruction execution
        if (wr_cmd && cmd.op == OP_STAL) begin
            mode_next = cmd.src_b;
        end else if (wr_cmd && state_reg == ST_IDLE) begin
            case (cmd.op)
                OP_ADD, OP_SUB: begin
                    sum = (cmd.op == OP_ADD) ? {1'b0, a_val} + {1'b0, b_val}
                                             : {1'b0, a_val} - {1'b0, b_val};
                    sgn_a = a_val[15];
                    sgn_b = (cmd.op == OP_ADD) ? b_val[15] : !b_val[15];
                    sgn_r = sum[15];
                    regs_next[cmd.dst] = sum[15:0];
                    cond_next[`F_CARRY] = sum[16];
                    cond_next[`F_ZERO] = sum[15:0] == 16'h0000;
                    cond_next[`F_NEG] = mode_reg[0] ? sgn_r : 1'b0;
                    cond_next[`F_UU] = !mode_reg[0] && cmd.op == OP_SUB && sum[16];
                    cond_next[`F_UO] = !mode_reg[0] && cmd.op == OP_ADD && sum[16];
                    cond_next[`F_SU] = mode_reg[0] && sgn_a && sgn_b && !sgn_r;
                    cond_next[`F_SO] = mode_reg[0] && !sgn_a && !sgn_b && sgn_r;
                    cond_next[`F_DONE] = 1'b1;
                end
                OP_MUL: begin
                    mcand_next = {16'h0000, a_val};
                    mplier_next = b_val;
                    wide_next = 32'h00000000;
                    cnt_next = 16'(`MUL_CYCLES - 1);
                    cond_next[`F_DONE] = 1'b0;
                    state_next = ST_MUL;
                end
                OP_AND: regs_next[cmd.dst] = a_val & mask_reg;
                OP_OR: regs_next[cmd.dst] = a_val | mask_reg;
                OP_XOR: regs_next[cmd.dst] = a_val ^ mask_reg;
                OP_NOT: regs_next[cmd.dst] = ~a_val;
                OP_SWAP: regs_next[cmd.dst] = {a_val[7:0], a_val[15:8]};
                OP_TO_TWOS_COMPLEMENT_OP: regs_next[cmd.dst] = {cond_reg[`F_CS], a_val[14:0]};
                OP_TOINT: begin
                    cond_next[`F_CS] = cmd.rst ? a_val[15]
                                               : cond_reg[`F_CS] ^ a_val[15];
                    regs_next[cmd.dst] = {1'b0, a_val[14:0]};
                end
                OP_WSHL, OP_WSHR, OP_SHL, OP_SHR, OP_SHLS, OP_SHRS, OP_BYTE_L,
                OP_BYTE_R: begin
                    if (cmd.op == OP_BYTE_L || cmd.op == OP_BYTE_R) begin
                        amt = 16'h0008;
                    end
                    kind_next = cmd.op[3:0];
                    // byte shifts run as plain shifts; their low opcode bits alias other ops
                    if (cmd.op == OP_BYTE_L) begin
                        kind_next = OP_SHL[3:0];
                    end else if (cmd.op == OP_BYTE_R) begin
                        kind_next = OP_SHR[3:0];
                    end
                    tgt_next = cmd.dst;
                    cond_next[`F_MO] = 1'b0;
                    cond_next[`F_ML] = 1'b0;
                    if (amt != 16'h0000) begin
                        cnt_next = amt - 16'h0001;
                        cond_next[`F_DONE] = 1'b0;
                        state_next = ST_SHIFT;
                    end else begin
                        cond_next[`F_DONE] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        case (state_reg)
            ST_MUL: begin
                if (mplier_reg[0]) begin
                    wide_next = wide_reg + mcand_reg;
                end
                mcand_next = {mcand_reg[30:0], 1'b0};
                mplier_next = {1'b0, mplier_reg[15:1]};
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000) begin
                    cond_next[`F_DONE] = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_SHIFT: begin
                case (opcode_t'({1'b0, kind_reg}))
                    OP_WSHL: begin
                        cond_next[`F_MO] = cond_reg[`F_MO] | wide_reg[31];
                        wide_next = {wide_reg[30:0], 1'b0};
                    end
                    OP_WSHR: begin
                        cond_next[`F_ML] = cond_reg[`F_ML] | wide_reg[0];
                        wide_next = {1'b0, wide_reg[31:1]};
                    end
                    OP_SHL, OP_SHLS: begin
                        cond_next[`F_SO] = regs_reg[tgt_reg][15];
                        regs_next[tgt_reg] = (kind_reg == OP_SHLS[3:0])
                            ? {regs_reg[tgt_reg][15], regs_reg[tgt_reg][13:0], 1'b0}
                            : {regs_reg[tgt_reg][14:0], 1'b0};
                    end
                    default: begin
                        cond_next[`F_SO] = regs_reg[tgt_reg][0];
                        regs_next[tgt_reg] = {(kind_reg == OP_SHRS[3:0])
                            && regs_reg[tgt_reg][15], regs_reg[tgt_reg][15:1]};
                    end
                endcase
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0000) begin
                    cond_next[`F_DONE] = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `REG_CNT; i++) begin
                regs_reg[i] <= 16'h0000;
            end
            mask_reg <= 16'h0000;
            wide_reg <= 32'h00000000;
            cond_reg <= 11'h200;
            mode_reg <= 2'h0;
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            mcand_reg <= 32'h00000000;
            mplier_reg <= 16'h0000;
            kind_reg <= 4'h0;
            tgt_reg <= 2'h0;
            dat_o <= 32'h00000000;
            ack_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            regs_reg <= regs_next;
            mask_reg <= mask_next;
            wide_reg <= wide_next;
            cond_reg <= cond_next;
            mode_reg <= mode_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            mcand_reg <= mcand_next;
            mplier_reg <= mplier_next;
            kind_reg <= kind_next;
            tgt_reg <= tgt_next;
            dat_o <= dat_next;
            ack_o <= ack_next;
            busy_o <= state_next != ST_IDLE;
        end
    end
endmodule
